// File: rtl/tec_pkg.sv
// Constants for the receive error counters and second interrupt mask.
// Assumes a 100 MHz system clock and a one-cycle receive bit enable.
//
// Behaviour
// R1 - Eight-bit mask register; bits 7..1 enable listed interrupts, bit 0 unused.
// R2 - All error count registers update at each one-second timer boundary.
// R3 - Software reads counts within one second of each update.
// R4 - Counters saturate at their maximum and never wrap to zero.
// R5 - Line violation count is 16 bits, high byte 0x23, low 0x24.
// R6 - Count bipolar violations; optionally 16 zeros, or 8 with substitution decoding.
// R7 - Valid substitution code words are excluded from the line count.
// R8 - Line violation counter counts even during loss of sync.
// R9 - ESF: path counter counts CRC6 errors, Fs option ignored.
// R10 - D4: path counter counts Ft errors, plus Fs errors if enabled.
// R11 - Path counter stops counting during loss of sync.
// R12 - Path bits 11..8 in low nibble of 0x25, bits 7..0 at 0x26.
// R13 - One-second tick from receive clock, spaced 999, 999, 1002 ms.
// R14 - At each boundary, copy accumulator to register and restart from zero.
`default_nettype none
package tec_pkg;
  localparam logic [7:0] ADDR_LINE_HIGH  = 8'h23;
  localparam logic [7:0] ADDR_LINE_LOW   = 8'h24;
  localparam logic [7:0] ADDR_PATH_HIGH  = 8'h25;
  localparam logic [7:0] ADDR_PATH_LOW   = 8'h26;
  localparam logic [7:0] ADDR_MASK_TWO   = 8'h6F;
  localparam logic [7:0] ADDR_STATUS     = 8'h70;
  localparam logic [7:0] ADDR_CONTROL    = 8'h71;
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] MASK_WRITABLE   = 8'hFE;
  localparam int         MASK_SEC_BIT    = 5;
  localparam int         CTL_EXZ_BIT     = 0;
  localparam int         CTL_FS_BIT      = 1;
  localparam int         CTL_B8ZS_BIT    = 2;
  localparam int         CTL_ESF_BIT     = 3;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  localparam int         ZERO_RUN_PLAIN  = 16;
  localparam int         ZERO_RUN_SUBST  = 8;
  localparam int         LINE_WIDTH      = 16;
  localparam int         PATH_WIDTH      = 12;
  localparam int         BIT_RATE_HZ     = 1544000;
  localparam int         SHORT_SEC_MS    = 999;
  localparam int         LONG_SEC_MS     = 1002;
  localparam int         SHORT_SEC_BITS  = BIT_RATE_HZ / 1000 * SHORT_SEC_MS;
  localparam int         LONG_SEC_BITS   = BIT_RATE_HZ / 1000 * LONG_SEC_MS;
endpackage : tec_pkg
`default_nettype wire

// File: rtl/tec_sat_counter.sv
// Saturating accumulator with a latched readable copy.
// Assumes the latch pulse lasts one cycle.
`default_nettype none
module tec_sat_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             inc,
  input  wire logic             latch,
  output logic      [WIDTH-1:0] held
);
  logic [WIDTH-1:0] acc_r;
  logic [WIDTH-1:0] acc_nxt;
  logic [WIDTH-1:0] held_r;
  wire              at_max = &acc_r;
  wire  [WIDTH-1:0] acc_inc = at_max ? acc_r : acc_r + 1'b1; // see R4
  // An event in the latch cycle lands in the fresh second
  assign acc_nxt = latch ? {{(WIDTH-1){1'b0}}, inc} : (inc ? acc_inc : acc_r); // see R14
  assign held    = held_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_r  <= '0;
      held_r <= '0;
    end else begin
      acc_r <= acc_nxt;
      // Latch-cycle event goes only to the new second, never to both
      if (latch) begin
        held_r <= acc_r; // see R2, see R14
      end
    end
  end
endmodule : tec_sat_counter
`default_nettype wire

// File: rtl/tec_error_counters.sv
// Receive line and path error counters, one-second timer and second mask.
// Assumes rx_bit_en pulses once per received bit and events are one-cycle pulses.
`default_nettype none
module tec_error_counters #(
  parameter int SHORT_SEC_BITS = tec_pkg::SHORT_SEC_BITS,
  parameter int LONG_SEC_BITS  = tec_pkg::LONG_SEC_BITS
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       rx_bit_en,
  input  wire logic       rx_zero,
  input  wire logic       bipolar_violation,
  input  wire logic       subst_code_word,
  input  wire logic       crc6_error,
  input  wire logic       ft_error,
  input  wire logic       fs_error,
  input  wire logic       receive_sync_lost,
  input  wire logic [3:0] out_of_sync_multiframe_counter,
  input  wire logic [6:0] other_events,
  output logic            one_second_event,
  output logic      [7:0] event_interrupt_mask_two,
  output logic            irq
);
  ////////////////////////////////////////////////////////////////////////////
  // One-second timer
  logic [31:0] sec_cnt_r;
  logic [1:0]  sec_phase_r;
  wire  [31:0] sec_len  = (sec_phase_r == 2'd2) ? LONG_SEC_BITS[31:0] : SHORT_SEC_BITS[31:0]; // see R13
  wire         sec_tick = rx_bit_en && (sec_cnt_r == sec_len - 32'd1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_cnt_r   <= 32'h0000_0000;
      sec_phase_r <= 2'd0;
    end else if (rx_bit_en) begin
      sec_cnt_r   <= sec_tick ? 32'h0000_0000 : sec_cnt_r + 32'd1;
      if (sec_tick) begin
        sec_phase_r <= (sec_phase_r == 2'd2) ? 2'd0 : sec_phase_r + 2'd1; // see R13
      end
    end
  end
  assign one_second_event = sec_tick;

  ////////////////////////////////////////////////////////////////////////////
  // Control bits
  logic [7:0] control_r;
  logic [7:0] mask_r;
  wire        exz_en  = control_r[tec_pkg::CTL_EXZ_BIT];
  wire        fs_en   = control_r[tec_pkg::CTL_FS_BIT];
  wire        b8zs_en = control_r[tec_pkg::CTL_B8ZS_BIT];
  wire        esf_sel = control_r[tec_pkg::CTL_ESF_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Excessive zeros
  logic [4:0] zero_run_r;
  wire  [4:0] zero_limit = b8zs_en ? 5'(tec_pkg::ZERO_RUN_SUBST) : 5'(tec_pkg::ZERO_RUN_PLAIN); // see R6
  wire        zero_hit   = rx_bit_en && rx_zero && (zero_run_r == zero_limit - 5'd1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_run_r <= 5'd0;
    end else if (rx_bit_en) begin
      zero_run_r <= (!rx_zero || zero_hit) ? 5'd0 : zero_run_r + 5'd1;
    end
  end
  // Substitution words carry deliberate violations; drop them when decoding
  wire bpv_counted = bipolar_violation && !(b8zs_en && subst_code_word); // see R7
  // No sync gating on the line count
  wire line_inc = bpv_counted || (exz_en && zero_hit); // see R6, see R8
  wire path_src = esf_sel ? crc6_error : (ft_error || (fs_en && fs_error)); // see R9, see R10
  wire path_inc = path_src && !receive_sync_lost; // see R11

  ////////////////////////////////////////////////////////////////////////////
  // Counters
  logic [tec_pkg::LINE_WIDTH-1:0] line_count;
  logic [tec_pkg::PATH_WIDTH-1:0] path_count;
  tec_sat_counter #(.WIDTH(tec_pkg::LINE_WIDTH)) u_line (
    .clk   (clk),
    .rst   (rst),
    .inc   (line_inc),
    .latch (sec_tick),
    .held  (line_count)
  ); // see R2, see R4, see R5
  tec_sat_counter #(.WIDTH(tec_pkg::PATH_WIDTH)) u_path (
    .clk   (clk),
    .rst   (rst),
    .inc   (path_inc),
    .latch (sec_tick),
    .held  (path_count)
  ); // see R2, see R4, see R12

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: bit 5 from own tick, bits 7..6 and 4..1 from framer events, bit 0 always zero
  logic [7:0] status_r;
  wire  [7:0] events    = {other_events[6:5], sec_tick, other_events[4:0]} & tec_pkg::MASK_WRITABLE;
  wire        rd_status = rd && (addr == tec_pkg::ADDR_STATUS);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= 8'h00;
    end else begin
      // Set wins over read-clear
      status_r <= (rd_status ? 8'h00 : status_r) | events;
    end
  end
  assign irq = |(status_r & mask_r); // see R1

  ////////////////////////////////////////////////////////////////////////////
  // Register port
  wire wr_mask = wr && (addr == tec_pkg::ADDR_MASK_TWO);
  wire wr_ctl  = wr && (addr == tec_pkg::ADDR_CONTROL);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r    <= tec_pkg::MASK_RESET;
      control_r <= tec_pkg::CONTROL_RESET;
    end else begin
      if (wr_mask) begin
        mask_r <= wdata & tec_pkg::MASK_WRITABLE; // see R1
      end
      if (wr_ctl) begin
        control_r <= wdata & 8'h0F;
      end
    end
  end
  assign event_interrupt_mask_two = mask_r;

  logic [7:0] rd_mux;
  always_comb begin
    unique case (addr)
      tec_pkg::ADDR_LINE_HIGH: rd_mux = line_count[15:8]; // see R5
      tec_pkg::ADDR_LINE_LOW:  rd_mux = line_count[7:0]; // see R5
      tec_pkg::ADDR_PATH_HIGH: rd_mux = {out_of_sync_multiframe_counter, path_count[11:8]}; // see R12
      tec_pkg::ADDR_PATH_LOW:  rd_mux = path_count[7:0]; // see R12
      tec_pkg::ADDR_MASK_TWO:  rd_mux = mask_r;
      tec_pkg::ADDR_STATUS:    rd_mux = status_r;
      tec_pkg::ADDR_CONTROL:   rd_mux = control_r;
      default:                 rd_mux = 8'h00;
    endcase
  end
  logic [7:0] rdata_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rd ? rd_mux : 8'h00;
    end
  end
  assign rdata = rdata_r;
endmodule : tec_error_counters
`default_nettype wire

// File: testbench/tec_error_counters_properties.sv
// Port checker for the receive error counters.
// Assumes it is bound onto tec_error_counters.
`default_nettype none
module tec_error_counters_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       rx_bit_en,
  input wire logic [3:0] out_of_sync_multiframe_counter,
  input wire logic       one_second_event,
  input wire logic [7:0] event_interrupt_mask_two,
  input wire logic       irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_mask_wr;
    wr && addr == 8'h6F;
  endsequence
  sequence s_tick_armed;
    one_second_event && event_interrupt_mask_two[5] && !wr;
  endsequence
  a_mask_bit_zero: assert property (event_interrupt_mask_two[0] == 1'b0) else $error("mask bit 0 set");
  a_mask_write: assert property (s_mask_wr |=> event_interrupt_mask_two == {$past(wdata[7:1]), 1'b0})
    else $error("mask write lost");
  a_mask_hold: assert property (!(wr && addr == 8'h6F) |=> $stable(event_interrupt_mask_two))
    else $error("mask changed");
  a_mask_read: assert property (rd && addr == 8'h6F |=> rdata == $past(event_interrupt_mask_two))
    else $error("mask readback");
  a_read_idle: assert property (!rd |=> rdata == 8'h00) else $error("rdata not idle");
  a_oos_nibble: assert property (rd && addr == 8'h25 |=> rdata[7:4] == $past(out_of_sync_multiframe_counter))
    else $error("upper nibble wrong");
  a_tick_pulse: assert property (one_second_event |-> rx_bit_en ##1 !one_second_event)
    else $error("tick not a pulse");
  a_tick_irq: assert property (s_tick_armed |=> irq) else $error("tick irq missing");
  a_irq_masked: assert property (event_interrupt_mask_two == 8'h00 && $past(event_interrupt_mask_two) == 8'h00 |-> !irq)
    else $error("irq while masked");
endmodule : tec_error_counters_properties
`default_nettype wire

// File: testbench/tec_error_counters_tb.sv
// Self-checking bench for the receive error counters.
// Assumes short seconds and a bit enable high every cycle.
`default_nettype none
module tec_error_counters_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, wr, rd, rx_zero, sync_lost, bit_en, sec, irq;
  logic [7:0] addr, wdata, rdata, mask, rv;
  logic [4:0] ev;
  logic [6:0] oth;
  logic [3:0] oos;
  int         failures, cmp_count;
  // Second just over 4095 cycles so the path count can saturate
  tec_error_counters #(.SHORT_SEC_BITS(4110), .LONG_SEC_BITS(4113)) dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_bit_en(bit_en), .rx_zero(rx_zero), .bipolar_violation(ev[0]), .subst_code_word(ev[1]),
    .crc6_error(ev[2]), .ft_error(ev[3]), .fs_error(ev[4]), .receive_sync_lost(sync_lost),
    .out_of_sync_multiframe_counter(oos), .other_events(oth), .one_second_event(sec),
    .event_interrupt_mask_two(mask), .irq(irq));
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [7:0] a);
    @(posedge clk) begin addr <= a; rd <= 1'b1; end
    @(posedge clk) rd <= 1'b0;
    #1 rv = rdata;
  endtask : rd_reg
  task tick;
    int i;
    i = 0;
    do begin @(negedge clk); i++; end while (!sec && i < 5000);
  endtask : tick
  task pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk) ev[k] <= 1'b1;
      @(posedge clk) ev[k] <= 1'b0;
    end
  endtask : pulse
  task counts(input logic [15:0] el, input logic [11:0] ep);
    tick;
    // Reads follow the boundary at once, well inside the second
    rd_reg(8'h23);
    chk(rv, el[15:8]);
    rd_reg(8'h24);
    chk(rv, el[7:0]);
    rd_reg(8'h25);
    chk(rv, {oos, ep[11:8]});
    rd_reg(8'h26);
    chk(rv, ep[7:0]);
  endtask : counts
  // Two violations, two CRC, three Ft, one Fs and a 17-zero run per second
  task sec_case(input logic [7:0] ctl, input logic [15:0] el, input logic [11:0] ep);
    wr_reg(8'h71, ctl);
    tick;
    pulse(0, 2);
    pulse(2, 2);
    pulse(3, 3);
    pulse(4, 1);
    @(posedge clk) rx_zero <= 1'b1;
    repeat (17) @(posedge clk);
    rx_zero <= 1'b0;
    counts(el, ep);
  endtask : sec_case
  ////////////////////////////////////////////////////////////////////////////
  task t_mask;
    rd_reg(8'h6F);
    chk(rv, 8'h00);
    wr_reg(8'h6F, 8'hFF);
    rd_reg(8'h6F);
    chk(rv, 8'hFE);
    rd_reg(8'h30);
    chk(rv, 8'h00);
    $display("mask test done");
  endtask : t_mask
  task t_counts;
    sec_case(8'h00, 16'd2, 12'd3);
    sec_case(8'h01, 16'd3, 12'd3);
    sec_case(8'h05, 16'd4, 12'd3);
    sec_case(8'h08, 16'd2, 12'd2);
    sec_case(8'h0A, 16'd2, 12'd2);
    sec_case(8'h02, 16'd2, 12'd4);
    @(posedge clk) sync_lost <= 1'b1;
    sec_case(8'h00, 16'd2, 12'd0);
    @(posedge clk) sync_lost <= 1'b0;
    $display("count test done");
  endtask : t_counts
  task t_subst;
    wr_reg(8'h71, 8'h04);
    tick;
    @(posedge clk) begin ev[0] <= 1'b1; ev[1] <= 1'b1; end
    @(posedge clk) begin ev[0] <= 1'b0; ev[1] <= 1'b0; end
    pulse(0, 1);
    counts(16'd1, 12'd0);
    wr_reg(8'h71, 8'h00);
    tick;
    @(posedge clk) begin ev[0] <= 1'b1; ev[1] <= 1'b1; end
    @(posedge clk) begin ev[0] <= 1'b0; ev[1] <= 1'b0; end
    pulse(0, 1);
    counts(16'd2, 12'd0);
    $display("substitution test done");
  endtask : t_subst
  task t_sat;
    wr_reg(8'h71, 8'h08);
    tick;
    @(posedge clk) ev[2] <= 1'b1;
    repeat (4100) @(posedge clk);
    ev[2] <= 1'b0;
    counts(16'd0, 12'hFFF);
    $display("saturation test done");
  endtask : t_sat
  task t_irq;
    wr_reg(8'h6F, 8'h20);
    rd_reg(8'h70);
    chk({7'h00, irq}, 8'h00);
    tick;
    @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk) oth[6] <= 1'b1;
    @(posedge clk) oth[6] <= 1'b0;
    rd_reg(8'h70);
    chk(rv, 8'hA0);
    rd_reg(8'h70);
    chk(rv, 8'h00);
    $display("interrupt test done");
  endtask : t_irq
  task final_report;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // About twenty-one seconds of 4110 cycles are needed
  initial begin
    #1_000_000;
    failures++;
    final_report;
  end
  initial begin
    {rst, wr, rd, rx_zero, sync_lost, bit_en} = 6'b100001;
    {addr, wdata, ev, oth, oos} = {8'h00, 8'h00, 5'h00, 7'h00, 4'hA};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_mask;
    t_counts;
    t_subst;
    t_sat;
    t_irq;
    final_report;
  end
endmodule : tec_error_counters_tb
bind tec_error_counters tec_error_counters_properties u_props (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_bit_en(rx_bit_en),
  .out_of_sync_multiframe_counter(out_of_sync_multiframe_counter), .one_second_event(one_second_event),
  .event_interrupt_mask_two(event_interrupt_mask_two), .irq(irq));
`default_nettype wire
